// [rtl/syp_defs.vh]
`ifndef SYP_DEFS_VH
`define SYP_DEFS_VH

// Register byte offsets (low address nibble)
`define SYP_OFS_STATUS   4'h0
`define SYP_OFS_CONTROL  4'h4
`define SYP_OFS_BUFFER   4'h8

// Status register fields
`define SYP_ST_SMP       7
`define SYP_ST_CKE       6
`define SYP_ST_BF        0

// Control register fields
`define SYP_CT_WRITE_COLLISION      7
`define SYP_CT_OV        6
`define SYP_CT_EN        5
`define SYP_CT_CKP       4
`define SYP_CT_MODE_HI   3
`define SYP_CT_MODE_LO   0

// Mode codes
`define SYP_MODE_DIV4    4'h0
`define SYP_MODE_DIV16   4'h1
`define SYP_MODE_DIV64   4'h2
`define SYP_MODE_TIMER_TWO    4'h3
`define SYP_MODE_SLV_SS  4'h4
`define SYP_MODE_SLV     4'h5

// Half serial clock periods in system clocks
`define SYP_HALF_DIV4    6'd2
`define SYP_HALF_DIV16   6'd8
`define SYP_HALF_DIV64   6'd32

// Master edge index of the closing tick
`define SYP_LAST_EDGE    5'd16
// Index of the last bit in a word
`define SYP_LAST_BIT     4'd7

// Reset values
`define SYP_RST_BYTE     8'h00
`define SYP_RST_WORD     32'h0000_0000

`endif

// [rtl/syp_spi_port.v]
// Function
// - Each transfer shifts eight bits out and eight in together, locked to the serial clock.
// - Master drives the serial clock; slave takes it from the clock pin.
// - Master samples input at end of bit time when bit 7 set, else middle.
// - Clock edge select with idle polarity picks the transmit edge.
// - Clock idle polarity bit sets the serial clock rest level.
// - Buffer full flag sets when a received word lands in the buffer.
// - Software read of the transfer buffer clears buffer full.
// - Write collision flag sets on buffer write during a transfer; software clears it.
// - Overflow flag sets when a word completes with buffer unread; word is dropped.
// - Overflow only happens in slave mode, never in master mode.
// - Master transfers start when software writes the transfer buffer.
// - Enable bit hands the pins to the port; clearing returns them to I/O.
// - Codes 0000 to 0011 select master at clock/4, /16, /64 or timer two/2.
// - Code 0100 is slave with select control; 0101 slave ignoring select.
// - With select control, inactive high select resets the transfer state.
// - With select control, high select makes the output direction bit read as set.
`timescale 1ns/1ps
`include "syp_defs.vh"
`default_nettype none

module syp_spi_port (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  input  wire        sck_i,
  output wire        sck_o,
  output wire        sck_oe_o,
  input  wire        sdi_i,
  output wire        sdo_o,
  output wire        sdo_oe_o,
  input  wire        ss_n_i,
  input  wire        timer_two_i,
  output wire        port_enable_o,
  output wire        sdo_dir_readback_o
);

  // Master mode codes
  function is_master;
    input [3:0] m;
    begin
      is_master = (m == `SYP_MODE_DIV4) || (m == `SYP_MODE_DIV16) ||
                  (m == `SYP_MODE_DIV64) || (m == `SYP_MODE_TIMER_TWO);
    end
  endfunction

  // Slave mode codes
  function is_slave;
    input [3:0] m;
    begin
      is_slave = (m == `SYP_MODE_SLV_SS) || (m == `SYP_MODE_SLV);
    end
  endfunction

  // Configuration bits
  reg        smp_ff;
  reg        cke_ff;
  reg        ckp_ff;
  reg        en_ff;
  reg [3:0]  mode_ff;

  // Sticky status flags
  reg        write_collision_ff;
  reg        ov_ff;
  reg        bf_ff;

  // Receive buffer and shift registers
  reg [7:0]  buf_ff;
  reg [7:0]  tx_ff;
  reg [7:0]  rx_ff;

  // Master sequencer and clock generator state
  reg        busy_ff;
  reg [4:0]  edge_ff;
  reg [5:0]  div_ff;
  reg        sck_ff;

  // Slave bit count and clock pin history
  reg [3:0]  cnt_ff;
  reg        sck_prev_ff;

  // Register bus answer
  reg        ack_ff;
  reg [31:0] dat_ff;

  // Output direction readback, one clock behind select
  reg        sdo_dir_ff;

  // Mode and bus decode
  wire       master;
  wire       slave;
  wire       ss_idle;
  wire       wb_req;
  wire       wr_acc;
  wire       rd_acc;
  wire       hit_stat;
  wire       hit_ctl;
  wire       hit_buf;
  wire       buf_wr;
  wire       buf_rd;
  wire       collide;

  // Master edge timing
  reg  [5:0] half;
  wire       tick;
  wire       even;
  wire       last;
  wire       m_sample;
  wire       m_shift;
  wire       m_done;

  // Slave edge detection
  wire       sck_chg;
  wire       lead;
  wire       trail;
  wire       s_act;
  wire       s_sample;
  wire       s_shift;
  wire       s_done;

  // Shared word assembly and read data
  wire       sample;
  wire       done;
  wire [7:0] rx_next;
  wire [7:0] rx_word;
  wire       drop;
  reg  [7:0] rd_byte;

  // Mode decode
  assign master  = en_ff & is_master(mode_ff);
  assign slave   = en_ff & is_slave(mode_ff);
  assign ss_idle = en_ff & (mode_ff == `SYP_MODE_SLV_SS) & ss_n_i;

  // Bus decode; side effects happen on the edge that sees ack
  assign wb_req   = wb_cyc_i & wb_stb_i;
  assign wr_acc   = wb_req & ack_ff & wb_we_i & wb_sel_i[0];
  assign rd_acc   = wb_req & ack_ff & ~wb_we_i;
  assign hit_stat = (wb_adr_i == `SYP_OFS_STATUS);
  assign hit_ctl  = (wb_adr_i == `SYP_OFS_CONTROL);
  assign hit_buf  = (wb_adr_i == `SYP_OFS_BUFFER);
  assign buf_wr   = wr_acc & hit_buf;
  assign buf_rd   = rd_acc & hit_buf;
  assign collide  = buf_wr & (master ? busy_ff : (slave & (cnt_ff != 4'd0)));

  // Master bit rate select
  always @* begin
    case (mode_ff)
      `SYP_MODE_DIV4:  half = `SYP_HALF_DIV4;
      `SYP_MODE_DIV16: half = `SYP_HALF_DIV16;
      `SYP_MODE_DIV64: half = `SYP_HALF_DIV64;
      default:         half = `SYP_HALF_DIV4;
    endcase
  end

  // Half period tick from divider or timer two
  assign tick = busy_ff & ((mode_ff == `SYP_MODE_TIMER_TWO) ? timer_two_i : (div_ff == (half - 6'd1)));

  // Master edge roles; even index is the leading edge
  assign even     = ~edge_ff[0];
  assign last     = (edge_ff == `SYP_LAST_EDGE);
  assign m_sample = tick & (smp_ff ? (cke_ff ? (even & (edge_ff != 5'd0)) : ~even)
                                   : (cke_ff ? ~even : (even & ~last)));
  assign m_shift  = tick & (cke_ff ? (even & (edge_ff != 5'd0) & ~last) : ~even);
  assign m_done   = tick & last;

  // Slave edge roles from the clock pin
  assign sck_chg  = sck_i ^ sck_prev_ff;
  assign lead     = sck_chg & (sck_i != ckp_ff);
  assign trail    = sck_chg & (sck_i == ckp_ff);
  assign s_act    = slave & ~ss_idle;
  assign s_sample = s_act & (cke_ff ? trail : lead);
  assign s_shift  = s_act & (cke_ff ? (lead & (cnt_ff != 4'd0)) : trail);
  assign s_done   = s_sample & (cnt_ff == `SYP_LAST_BIT);

  // Word assembly, MSB first
  assign sample  = m_sample | s_sample;
  assign done    = m_done | s_done;
  assign rx_next = {rx_ff[6:0], sdi_i};
  assign rx_word = sample ? rx_next : rx_ff;
  assign drop    = done & slave & bf_ff;

  // Register read mux
  always @* begin
    rd_byte = `SYP_RST_BYTE;
    if (hit_stat) begin
      rd_byte[`SYP_ST_SMP] = smp_ff;
      rd_byte[`SYP_ST_CKE] = cke_ff;
      rd_byte[`SYP_ST_BF]  = bf_ff;
    end else if (hit_ctl) begin
      rd_byte = {write_collision_ff, ov_ff, en_ff, ckp_ff, mode_ff};
    end else if (hit_buf) begin
      rd_byte = buf_ff;
    end
  end

  // Wishbone slave: one wait state, unmapped reads zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      dat_ff <= `SYP_RST_WORD;
    end else begin
      ack_ff <= wb_req & ~ack_ff;
      if (wb_req & ~ack_ff) begin
        dat_ff <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Configuration registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      smp_ff  <= 1'b0;
      cke_ff  <= 1'b0;
      ckp_ff  <= 1'b0;
      en_ff   <= 1'b0;
      mode_ff <= 4'h0;
    end else begin
      if (wr_acc & hit_stat) begin
        smp_ff <= wb_dat_i[`SYP_ST_SMP];
        cke_ff <= wb_dat_i[`SYP_ST_CKE];
      end
      if (wr_acc & hit_ctl) begin
        en_ff   <= wb_dat_i[`SYP_CT_EN];
        ckp_ff  <= wb_dat_i[`SYP_CT_CKP];
        mode_ff <= wb_dat_i[`SYP_CT_MODE_HI:`SYP_CT_MODE_LO];
      end
    end
  end

  // Sticky flags; hardware set wins over software write
  always @(posedge clk_i) begin
    if (rst_i) begin
      write_collision_ff <= 1'b0;
      ov_ff   <= 1'b0;
      bf_ff   <= 1'b0;
    end else begin
      write_collision_ff <= collide | ((wr_acc & hit_ctl) ? wb_dat_i[`SYP_CT_WRITE_COLLISION] : write_collision_ff);
      ov_ff   <= drop | ((wr_acc & hit_ctl) ? wb_dat_i[`SYP_CT_OV] : ov_ff);
      bf_ff   <= (done & ~drop) | (bf_ff & ~buf_rd);
    end
  end

  // Receive buffer load
  always @(posedge clk_i) begin
    if (rst_i) begin
      buf_ff <= `SYP_RST_BYTE;
    end else if (done & ~drop) begin
      buf_ff <= rx_word;
    end
  end

  // Transmit and receive shift registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      tx_ff <= `SYP_RST_BYTE;
      rx_ff <= `SYP_RST_BYTE;
    end else begin
      if (buf_wr & ~collide) begin
        tx_ff <= wb_dat_i[7:0];
      end else if (m_shift | s_shift) begin
        tx_ff <= {tx_ff[6:0], 1'b0};
      end
      if (ss_idle | ~en_ff) begin
        rx_ff <= `SYP_RST_BYTE;
      end else if (sample) begin
        rx_ff <= rx_next;
      end
    end
  end

  // Master sequencer and clock generator
  always @(posedge clk_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
      edge_ff <= 5'd0;
      div_ff  <= 6'd0;
      sck_ff  <= 1'b0;
    end else if (~master) begin
      busy_ff <= 1'b0;
      edge_ff <= 5'd0;
      div_ff  <= 6'd0;
      sck_ff  <= ckp_ff;
    end else if (~busy_ff) begin
      sck_ff <= ckp_ff;
      if (buf_wr) begin
        busy_ff <= 1'b1;
        edge_ff <= 5'd0;
        div_ff  <= 6'd0;
      end
    end else if (tick) begin
      div_ff  <= 6'd0;
      edge_ff <= edge_ff + 5'd1;
      if (last) begin
        busy_ff <= 1'b0;
      end else begin
        sck_ff <= ~sck_ff;
      end
    end else begin
      div_ff <= div_ff + 6'd1;
    end
  end

  // Slave bit counter and clock pin history
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff      <= 4'd0;
      sck_prev_ff <= 1'b0;
      sdo_dir_ff  <= 1'b0;
    end else begin
      sck_prev_ff <= sck_i;
      sdo_dir_ff  <= ss_idle;
      if (~s_act) begin
        cnt_ff <= 4'd0;
      end else if (s_sample) begin
        cnt_ff <= s_done ? 4'd0 : (cnt_ff + 4'd1);
      end
    end
  end

  // Pin and bus outputs
  assign wb_ack_o           = ack_ff;
  assign wb_dat_o           = dat_ff;
  assign sck_o              = sck_ff;
  assign sck_oe_o           = master;
  assign sdo_o              = tx_ff[7];
  assign sdo_oe_o           = master | s_act;
  assign port_enable_o      = en_ff;
  assign sdo_dir_readback_o = sdo_dir_ff;

endmodule // syp_spi_port

`default_nettype wire

// [verif/syp_echo_model.sv]
`timescale 1ns/1ps
`default_nettype none
module syp_echo_model #(
  parameter logic [7:0] INIT = 8'h3c
) (
  input  wire logic       rst_i,
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  output logic            miso_o,
  output logic      [7:0] word_o
);
  // Rising edge samples, MSB first
  always @(posedge sck_i or posedge rst_i) begin
    if (rst_i) word_o <= INIT;
    else word_o <= {word_o[6:0], mosi_i};
  end
  // Falling edge presents the next bit
  always @(negedge sck_i or posedge rst_i) begin
    if (rst_i) miso_o <= INIT[7];
    else miso_o <= word_o[7];
  end
endmodule // syp_echo_model
`default_nettype wire

// [verif/syp_spi_port_props.sv]
`timescale 1ns/1ps
`default_nettype none
module syp_spi_port_props (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        sck_o,
  input wire logic        sck_oe_o,
  input wire logic        sdo_oe_o,
  input wire logic        port_enable_o,
  input wire logic        sdo_dir_readback_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // New bus request, and a control write among them
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ctl_wr;
    s_req ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h4);
  endsequence
  a_ack_answer: assert property (s_req |=> wb_ack_o)
    else $error("ack missing");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_read_width: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (s_req ##0 (!wb_we_i && wb_adr_i == 4'hc) |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_enable_write: assert property (s_ctl_wr |-> ##2 port_enable_o == $past(wb_dat_i[5], 2))
    else $error("enable bit not stored");
  a_clock_drive_en: assert property (sck_oe_o |-> port_enable_o)
    else $error("clock driven while disabled");
  a_data_drive_en: assert property (!port_enable_o |-> !sdo_oe_o)
    else $error("data driven while disabled");
  a_sck_hold: assert property (sck_oe_o && $changed(sck_o) |=> $stable(sck_o) || !sck_oe_o)
    else $error("serial clock half too short");
  a_select_off: assert property ($rose(sdo_dir_readback_o) |-> !sdo_oe_o)
    else $error("output on while deselected");
endmodule // syp_spi_port_props
bind syp_spi_port syp_spi_port_props u_syp_spi_port_props (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .sck_o(sck_o), .sck_oe_o(sck_oe_o), .sdo_oe_o(sdo_oe_o), .port_enable_o(port_enable_o),
  .sdo_dir_readback_o(sdo_dir_readback_o));
`default_nettype wire

// [verif/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk_i, rst_i, cyc, stb, we, sck_t, sdi_t, ss_n, tmr, slv, miso;
  logic        ack, sck, sck_oe, serial_output, sdo_oe, en, rb;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [7:0]  got, prev;
  logic [2:0]  tcnt;
  logic [7:0]  tx [4] = '{8'ha5, 8'h5a, 8'hc3, 8'h01};
  int          failures = 0;
  int          n_tests = 0;
  syp_spi_port u_syp_spi_port (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sck_i(sck_t),
    .sck_o(sck), .sck_oe_o(sck_oe), .sdi_i(slv ? sdi_t : miso), .sdo_o(serial_output), .sdo_oe_o(sdo_oe),
    .ss_n_i(ss_n), .timer_two_i(tmr), .port_enable_o(en), .sdo_dir_readback_o(rb));
  syp_echo_model u_syp_echo_model (.rst_i(rst_i), .sck_i(sck), .mosi_i(serial_output), .miso_o(miso), .word_o(got));
  // Clock and timer pulse every eight clocks
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    tcnt <= rst_i ? 3'd0 : (tcnt + 3'd1);
    tmr <= ~rst_i && (tcnt == 3'd0);
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One classic bus cycle, read data left in q
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    q = rdat;
    if (n == 20) failures++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input string nm, input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 8'h00);
    chk(nm, q & m, e);
  endtask
  task automatic waitbf;
    int n;
    n = 0;
    q = 32'h0;
    while (q[0] !== 1'b1 && n < 400) begin
      wb(1'b0, 4'h0, 8'h00);
      n++;
    end
    if (n == 400) failures++;
  endtask
  // Far master sends one byte, MSB first, idle-low clock
  task automatic sbyte(input logic [7:0] b);
    for (int k = 7; k >= 0; k--) begin
      sdi_t <= b[k];
      repeat (3) @(posedge clk_i);
      sck_t <= 1'b1;
      repeat (3) @(posedge clk_i);
      sck_t <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
    repeat (3) @(posedge clk_i);
  endtask
  task automatic end_of_test;
    if (failures == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clk_i);
    failures++;
    end_of_test;
  end
  // Main sequence
  initial begin
    rst_i = 1'b1;
    ss_n = 1'b1;
    {cyc, stb, we, sck_t, sdi_t, slv} = '0;
    {adr, wdat} = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc("status", 4'h0, 32'hff, 32'h0);
    rdc("control", 4'h4, 32'hff, 32'h0);
    rdc("unmapped", 4'hc, 32'hffffffff, 32'h0);
    prev = 8'h3c;
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, 4'h4, 8'h00);
      wb(1'b1, 4'h4, 8'h20 | 8'(i));
      chk("sck_oe", {31'h0, sck_oe}, 32'h1);
      wb(1'b1, 4'h8, tx[i]);
      if (i == 0) begin
        wb(1'b1, 4'h8, 8'hff);
        rdc("write_collision", 4'h4, 32'h80, 32'h80);
      end
      waitbf;
      rdc("ov", 4'h4, 32'h40, 32'h0);
      rdc("rx", 4'h8, 32'hff, {24'h0, prev});
      rdc("bf", 4'h0, 32'h01, 32'h0);
      chk("far word", {24'h0, got}, {24'h0, tx[i]});
      prev = tx[i];
    end
    // Master reload while full: no overflow
    wb(1'b1, 4'h8, 8'h77);
    waitbf;
    wb(1'b1, 4'h8, 8'h88);
    repeat (160) @(posedge clk_i);
    rdc("ov", 4'h4, 32'h40, 32'h0);
    rdc("rx", 4'h8, 32'hff, 32'h77);
    // Slave with select control
    wb(1'b1, 4'h4, 8'h00);
    wb(1'b1, 4'h4, 8'h24);
    slv <= 1'b1;
    @(negedge clk_i);
    chk("readback", {31'h0, rb}, 32'h1);
    chk("sdo_oe", {31'h0, sdo_oe}, 32'h0);
    @(posedge clk_i);
    ss_n <= 1'b0;
    sbyte(8'h96);
    sbyte(8'h69);
    rdc("ov", 4'h4, 32'h40, 32'h40);
    rdc("rx", 4'h8, 32'hff, 32'h96);
    // Deselected slave ignores the clock
    ss_n <= 1'b1;
    sbyte(8'h55);
    rdc("bf deselected", 4'h0, 32'h01, 32'h0);
    // Slave with edge select 1 samples trailing edges
    wb(1'b1, 4'h4, 8'h00);
    rdc("ov cleared", 4'h4, 32'h40, 32'h0);
    wb(1'b1, 4'h0, 8'h40);
    wb(1'b1, 4'h4, 8'h24);
    @(posedge clk_i);
    ss_n <= 1'b0;
    sbyte(8'hc6);
    rdc("rx trailing", 4'h8, 32'hff, 32'hc6);
    // Idle-high clock
    wb(1'b1, 4'h4, 8'h00);
    wb(1'b1, 4'h4, 8'h30);
    @(negedge clk_i);
    chk("sck idle", {31'h0, sck}, 32'h1);
    @(posedge clk_i);
    end_of_test;
  end
endmodule // tb
`default_nettype wire
